// ### core/mbr_pkg.sv
// Constants, register map and timing for the multiplexed-bus memory/clock host
package mbr_pkg;
  // Clock and timing figures
  localparam int CLK_MHZ = 20;
  localparam int T_AS_NS = 20;
  localparam int T_ASLASH_NS = 15;
  localparam int T_ASHRW_NS = 15;
  localparam int T_DS_NS = 60;
  localparam int T_WLWH_NS = 50;
  localparam int T_RLDV_NS = 70;
  localparam int T_RLRH_NS = 70;
  localparam int T_RHDZ_NS = 25;
  localparam int T_REC_MIN_MS = 40;
  localparam int T_REC_MAX_MS = 200;

  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int AS_LOW_CYCLES = (T_AS_NS > T_ASLASH_NS) ? min_cycles(T_AS_NS) :
    min_cycles(T_ASLASH_NS);
  localparam int AS_RISE_CYCLES = min_cycles(T_ASHRW_NS);
  localparam int DS_CYCLES = min_cycles(T_DS_NS);
  localparam int WL_CYCLES = min_cycles(T_WLWH_NS);
  localparam int RD_CYCLES = (T_RLDV_NS > T_RLRH_NS) ? min_cycles(T_RLDV_NS) :
    min_cycles(T_RLRH_NS);
  localparam int RHDZ_CYCLES = min_cycles(T_RHDZ_NS);
  localparam int REC_MAX_CYCLES = T_REC_MAX_MS * CLK_MHZ * 1000;

  // Address layout
  localparam int LOW_ADDR_BITS = 8;
  localparam int HIGH_ADDR_BITS = 5;
  localparam int ADDR_BITS = LOW_ADDR_BITS + HIGH_ADDR_BITS;

  // Register map
  localparam logic [12:0] REG_STATUS_FLAGS = 13'h1ff0;
  localparam logic [12:0] REG_SPARE_BYTE = 13'h1ff1;
  localparam logic [12:0] REG_ALARM_SECOND_MATCH = 13'h1ff2;
  localparam logic [12:0] REG_ALARM_MINUTE_MATCH = 13'h1ff3;
  localparam logic [12:0] REG_ALARM_HOUR_MATCH = 13'h1ff4;
  localparam logic [12:0] REG_ALARM_DAY_OF_MONTH_MATCH = 13'h1ff5;
  localparam logic [12:0] REG_IRQ_ENABLES = 13'h1ff6;
  localparam logic [12:0] REG_WD_CONFIG = 13'h1ff7;
  localparam logic [12:0] REG_RTC_CONTROL = 13'h1ff8;
  localparam logic [12:0] REG_TIME_SECONDS = 13'h1ff9;
  localparam logic [12:0] REG_TIME_MINUTES = 13'h1ffa;
  localparam logic [12:0] REG_TIME_HOURS = 13'h1ffb;
  localparam logic [12:0] REG_WEEKDAY_AND_TEST = 13'h1ffc;
  localparam logic [12:0] REG_DAY_OF_MONTH = 13'h1ffd;
  localparam logic [12:0] REG_CALENDAR_MONTH = 13'h1ffe;
  localparam logic [12:0] REG_CALENDAR_YEAR = 13'h1fff;

  // Field positions
  localparam int CTRL_WRITE_HALT_BIT = 7;
  localparam int CTRL_READ_HALT_BIT = 6;
  localparam int CTRL_CAL_SIGN_BIT = 5;
  localparam int CTRL_CAL_MAG_LSB = 0;
  localparam int CTRL_CAL_MAG_BITS = 5;
  localparam int OSC_HALT_BIT = 7;
  localparam int FREQ_TEST_SEL_BIT = 6;
  localparam int WD_STEER_BIT = 7;
  localparam int WD_MULTIPLIER_LSB = 2;
  localparam int WD_MULTIPLIER_BITS = 5;
  localparam int WD_RESOLUTION_LSB = 0;
  localparam int WD_RESOLUTION_BITS = 2;
  localparam int ALARM_IRQ_EN_BIT = 7;
  localparam int ALARM_BACKUP_EN_BIT = 5;
  localparam int ALARM_REPEAT_BIT = 7;
  localparam int WD_TIMEOUT_FLAG_BIT = 7;
  localparam int ALARM_HIT_FLAG_BIT = 6;
  localparam int BATTERY_LOW_FLAG_BIT = 4;
  localparam logic [7:0] FLAGS_ZERO_MASK = 8'h2f;

  // Time value masks and ranges
  localparam logic [7:0] SEC_MIN_MASK = 8'h7f;
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] WEEKDAY_MASK = 8'h07;
  localparam logic [7:0] DATE_MASK = 8'h3f;
  localparam logic [7:0] MONTH_MASK = 8'h1f;
  localparam logic [7:0] SEC_MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WEEKDAY_MAX = 8'h07;
  localparam logic [7:0] DATE_MAX = 8'h31;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] ONE_BASED_MIN = 8'h01;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

  // Checks that a write to a time register carries a legal BCD value
  function automatic logic time_value_ok(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] v;
    logic [7:0] lo;
    logic [7:0] hi;
    v = d;
    lo = 8'h00;
    hi = YEAR_MAX;
    case (a)
      REG_TIME_SECONDS, REG_TIME_MINUTES:
      begin
        v = d & SEC_MIN_MASK;
        hi = SEC_MIN_MAX;
      end
      REG_TIME_HOURS:
      begin
        v = d & HOUR_MASK;
        hi = HOUR_MAX;
      end
      REG_WEEKDAY_AND_TEST:
      begin
        v = d & WEEKDAY_MASK;
        lo = ONE_BASED_MIN;
        hi = WEEKDAY_MAX;
      end
      REG_DAY_OF_MONTH:
      begin
        v = d & DATE_MASK;
        lo = ONE_BASED_MIN;
        hi = DATE_MAX;
      end
      REG_CALENDAR_MONTH:
      begin
        v = d & MONTH_MASK;
        lo = ONE_BASED_MIN;
        hi = MONTH_MAX;
      end
      REG_CALENDAR_YEAR:
      begin
        v = d;
      end
      default:
      begin
        v = 8'h00;
      end
    endcase
    return (v[3:0] <= BCD_DIGIT_MAX) && (v >= lo) && (v <= hi);
  endfunction

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_LOW_STROBE,
    ST_LOW_RISE,
    ST_HIGH_STROBE,
    ST_HIGH_RISE,
    ST_DATA_SETUP,
    ST_WRITE_PULSE,
    ST_WRITE_HOLD,
    ST_READ_PULSE,
    ST_READ_RELEASE
  } mbr_state_type;
endpackage

// ### core/mbr_recovery_guard.sv
// Power-fail lockout and post-recovery wait for the host
`timescale 1ns/1ps
`default_nettype none
module mbr_recovery_guard #(
  parameter int REC_CYCLES = mbr_pkg::REC_MAX_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerFail,
  output logic accessAllowed
);
  localparam int CW = $clog2(REC_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] left;
    logic allowed;
  } mbr_guard_type;

  mbr_guard_type s;
  mbr_guard_type next_s;

  always_comb
  begin
    next_s = s;
    if (powerFail)
    begin
      next_s.left = CW'(REC_CYCLES);
      next_s.allowed = 1'b0;
    end
    else if (s.left != '0)
    begin
      next_s.left = s.left - CW'(1);
      next_s.allowed = 1'b0;
    end
    else
    begin
      next_s.allowed = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{left: CW'(REC_CYCLES), allowed: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign accessAllowed = s.allowed;

  property p_fail_locks;
    @(posedge clk) disable iff (rst) powerFail |=> !accessAllowed;
  endproperty
  a_fail_locks: assert property (p_fail_locks) else $error("access open during power fail");
endmodule
`default_nettype wire

// ### core/mbr_host.sv
// Host controller driving the multiplexed-bus memory and clock device
// What this block does
// - Address bytes are latched low byte first, each with its own strobe, and only when changed or forgotten in a lockout.
// - Host drives data first, then asserts write enable; device stores it.
// - Host never asserts read enable and write enable together.
// - Time registers hold 24-hour BCD values within their stated ranges.
`timescale 1ns/1ps
`default_nettype none
module mbr_host #(
  parameter int REC_CYCLES = mbr_pkg::REC_MAX_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [12:0] reqAddr,
  input wire logic [7:0] reqData,
  output logic reqReady,
  output logic rspValid,
  output logic rspFault,
  output logic [7:0] rspData,
  output logic linkReady,
  input wire logic powerFail,
  input wire logic [7:0] muxedBusIn,
  output logic [7:0] muxedBusOut,
  output logic muxedBusOeN,
  output logic lowAddrStrobeN,
  output logic highAddrStrobeN,
  output logic readEnableN,
  output logic writeEnableN,
  output logic chipSelectN
);
  typedef struct packed {
    mbr_pkg::mbr_state_type state;
    logic [3:0] cnt;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic isWrite;
    logic [7:0] lowByte;
    logic [4:0] highByte;
    logic lowValid;
    logic highValid;
    logic [7:0] busOut;
    logic busOeN;
    logic lowStrobeN;
    logic highStrobeN;
    logic readN;
    logic writeN;
    logic selectN;
    logic rspValid;
    logic rspFault;
    logic [7:0] rspData;
  } mbr_host_type;

  mbr_host_type s;
  mbr_host_type next_s;
  logic accessAllowed;
  logic reqValueOk;

  mbr_recovery_guard #(
    .REC_CYCLES(REC_CYCLES)
  ) u_guard (
    .clk(clk),
    .rst(rst),
    .powerFail(powerFail),
    .accessAllowed(accessAllowed)
  );

  // Cycles spent in each state, minus one
  function automatic logic [3:0] entry_cnt(input mbr_pkg::mbr_state_type st);
    case (st)
      mbr_pkg::ST_LOW_STROBE, mbr_pkg::ST_HIGH_STROBE: entry_cnt = 4'(mbr_pkg::AS_LOW_CYCLES - 1);
      mbr_pkg::ST_LOW_RISE, mbr_pkg::ST_HIGH_RISE: entry_cnt = 4'(mbr_pkg::AS_RISE_CYCLES - 1);
      mbr_pkg::ST_DATA_SETUP: entry_cnt = 4'(mbr_pkg::DS_CYCLES - 1);
      mbr_pkg::ST_WRITE_PULSE: entry_cnt = 4'(mbr_pkg::WL_CYCLES - 1);
      mbr_pkg::ST_READ_PULSE: entry_cnt = 4'(mbr_pkg::RD_CYCLES - 1);
      mbr_pkg::ST_READ_RELEASE: entry_cnt = 4'(mbr_pkg::RHDZ_CYCLES - 1);
      default: entry_cnt = 4'h0;
    endcase
  endfunction

  assign reqValueOk = !reqWrite || mbr_pkg::time_value_ok(reqAddr, reqData);
  assign reqReady = (s.state == mbr_pkg::ST_IDLE) && accessAllowed;
  assign linkReady = accessAllowed;

  always_comb
  begin
    next_s = s;
    next_s.rspValid = 1'b0;
    if (s.cnt != 4'h0)
    begin
      next_s.cnt = s.cnt - 4'h1;
    end
    case (s.state)
      mbr_pkg::ST_IDLE:
      begin
        if (reqValid && reqReady)
        begin
          next_s.addr = reqAddr;
          next_s.wdata = reqData;
          next_s.isWrite = reqWrite;
          if (!reqValueOk)
          begin
            next_s.rspValid = 1'b1;
            next_s.rspFault = 1'b1;
          end
          else if (!s.lowValid || s.lowByte != reqAddr[7:0])
          begin
            next_s.state = mbr_pkg::ST_LOW_STROBE;
          end
          else if (!s.highValid || s.highByte != reqAddr[12:8])
          begin
            next_s.state = mbr_pkg::ST_HIGH_STROBE;
          end
          else
          begin
            next_s.state = reqWrite ? mbr_pkg::ST_DATA_SETUP : mbr_pkg::ST_READ_PULSE;
          end
        end
      end
      mbr_pkg::ST_LOW_STROBE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_LOW_RISE;
        end
      end
      mbr_pkg::ST_LOW_RISE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.lowByte = s.addr[7:0];
          next_s.lowValid = 1'b1;
          if (!s.highValid || s.highByte != s.addr[12:8])
          begin
            next_s.state = mbr_pkg::ST_HIGH_STROBE;
          end
          else
          begin
            next_s.state = s.isWrite ? mbr_pkg::ST_DATA_SETUP : mbr_pkg::ST_READ_PULSE;
          end
        end
      end
      mbr_pkg::ST_HIGH_STROBE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_HIGH_RISE;
        end
      end
      mbr_pkg::ST_HIGH_RISE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.highByte = s.addr[12:8];
          next_s.highValid = 1'b1;
          next_s.state = s.isWrite ? mbr_pkg::ST_DATA_SETUP : mbr_pkg::ST_READ_PULSE;
        end
      end
      mbr_pkg::ST_DATA_SETUP:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_WRITE_PULSE;
        end
      end
      mbr_pkg::ST_WRITE_PULSE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_WRITE_HOLD;
        end
      end
      mbr_pkg::ST_WRITE_HOLD:
      begin
        next_s.state = mbr_pkg::ST_IDLE;
        next_s.rspValid = 1'b1;
        next_s.rspFault = 1'b0;
      end
      mbr_pkg::ST_READ_PULSE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_READ_RELEASE;
          next_s.rspData = muxedBusIn;
          next_s.rspValid = 1'b1;
          next_s.rspFault = 1'b0;
        end
      end
      mbr_pkg::ST_READ_RELEASE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.state = mbr_pkg::ST_IDLE;
        end
      end
      default:
      begin
        next_s.state = mbr_pkg::ST_IDLE;
      end
    endcase
    // Lockout aborts any cycle and forgets the latched address
    if (!accessAllowed)
    begin
      next_s.lowValid = 1'b0;
      next_s.highValid = 1'b0;
      if (s.state != mbr_pkg::ST_IDLE)
      begin
        next_s.state = mbr_pkg::ST_IDLE;
        next_s.rspValid = 1'b1;
        next_s.rspFault = 1'b1;
      end
    end
    if (next_s.state != s.state)
    begin
      next_s.cnt = entry_cnt(next_s.state);
    end
    // Pin levels follow the state being entered
    next_s.busOeN = 1'b1;
    next_s.lowStrobeN = 1'b1;
    next_s.highStrobeN = 1'b1;
    next_s.readN = 1'b1;
    next_s.writeN = 1'b1;
    next_s.selectN = 1'b1;
    case (next_s.state)
      mbr_pkg::ST_LOW_STROBE, mbr_pkg::ST_LOW_RISE:
      begin
        next_s.busOut = next_s.addr[7:0];
        next_s.busOeN = 1'b0;
        next_s.lowStrobeN = (next_s.state != mbr_pkg::ST_LOW_STROBE);
      end
      mbr_pkg::ST_HIGH_STROBE, mbr_pkg::ST_HIGH_RISE:
      begin
        next_s.busOut = {3'b000, next_s.addr[12:8]};
        next_s.busOeN = 1'b0;
        next_s.highStrobeN = (next_s.state != mbr_pkg::ST_HIGH_STROBE);
      end
      mbr_pkg::ST_DATA_SETUP, mbr_pkg::ST_WRITE_PULSE, mbr_pkg::ST_WRITE_HOLD:
      begin
        next_s.busOut = next_s.wdata;
        next_s.busOeN = 1'b0;
        next_s.selectN = 1'b0;
        next_s.writeN = (next_s.state != mbr_pkg::ST_WRITE_PULSE);
      end
      mbr_pkg::ST_READ_PULSE:
      begin
        next_s.selectN = 1'b0;
        next_s.readN = 1'b0;
      end
      default:
      begin
        next_s.busOeN = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{state: mbr_pkg::ST_IDLE, busOeN: 1'b1, lowStrobeN: 1'b1, highStrobeN: 1'b1,
        readN: 1'b1, writeN: 1'b1, selectN: 1'b1, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rspValid = s.rspValid;
  assign rspFault = s.rspFault;
  assign rspData = s.rspData;
  assign muxedBusOut = s.busOut;
  assign muxedBusOeN = s.busOeN;
  assign lowAddrStrobeN = s.lowStrobeN;
  assign highAddrStrobeN = s.highStrobeN;
  assign readEnableN = s.readN;
  assign writeEnableN = s.writeN;
  assign chipSelectN = s.selectN;

  // Checks
  logic dataBeforeWrite;
  assign dataBeforeWrite = !muxedBusOeN && writeEnableN && !chipSelectN;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_no_both_enables;
    !(!readEnableN && !writeEnableN);
  endproperty
  a_no_both_enables: assert property (p_no_both_enables) else $error("read and write together");

  sequence s_data_setup;
    dataBeforeWrite [*2];
  endsequence
  sequence s_write_pulse;
    (!writeEnableN && !muxedBusOeN) ##1 (writeEnableN && !muxedBusOeN);
  endsequence
  property p_write_order;
    $fell(writeEnableN) |-> $past(dataBeforeWrite, 2) && $past(dataBeforeWrite) ##0 s_write_pulse;
  endproperty
  a_write_order: assert property (p_write_order) else $error("write without data setup");

  property p_setup_leads_write;
    $rose(dataBeforeWrite) && accessAllowed ##0 s_data_setup ##0 accessAllowed |=> !writeEnableN;
  endproperty
  a_setup_leads_write: assert property (p_setup_leads_write) else $error("write pulse late");

  property p_read_released;
    !readEnableN |-> muxedBusOeN && !chipSelectN;
  endproperty
  a_read_released: assert property (p_read_released) else $error("bus driven during read");

  property p_high_byte_clean;
    !highAddrStrobeN |-> !muxedBusOeN && muxedBusOut[7:5] == 3'b000;
  endproperty
  a_high_byte_clean: assert property (p_high_byte_clean) else $error("upper bits not zero");

  property p_strobe_edge_hold;
    $rose(lowAddrStrobeN) || $rose(highAddrStrobeN) |-> !muxedBusOeN && $stable(muxedBusOut);
  endproperty
  a_strobe_edge_hold: assert property (p_strobe_edge_hold) else $error("address moved at edge");

  property p_lockout_quiet;
    !accessAllowed |=> muxedBusOeN && readEnableN && writeEnableN && chipSelectN &&
      lowAddrStrobeN && highAddrStrobeN;
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet) else $error("pins active in lockout");

  property p_read_answer;
    $fell(readEnableN) && accessAllowed ##1 accessAllowed |=> readEnableN && rspValid && !rspFault;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer not on time");

  property p_bad_time_refused;
    reqValid && reqReady && reqWrite && !reqValueOk |=> rspValid && rspFault && writeEnableN
      ##1 writeEnableN;
  endproperty
  a_bad_time_refused: assert property (p_bad_time_refused) else $error("bad BCD written");
endmodule
`default_nettype wire

// ### test/mbr_device_model.sv
// Behavioural memory and clock device on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module mbr_device_model #(
  parameter int REC_NS = 800
) (
  input wire logic powerFail,
  input wire logic lowAddrStrobeN,
  input wire logic highAddrStrobeN,
  input wire logic readEnableN,
  input wire logic writeEnableN,
  input wire logic chipSelectN,
  input wire logic [7:0] hostOut,
  input wire logic hostOeN,
  output logic [7:0] busWire
);
  logic [7:0] mem [0:8191];
  logic [7:0] lowByte;
  logic [4:0] highByte;
  logic [7:0] lastVal;
  logic [7:0] rdVal;
  logic locked;
  logic drv;
  logic [12:0] addr;

  initial
  begin
    locked = 1'b0;
    lastVal = 8'h00;
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'h00;
    mem[mbr_pkg::REG_STATUS_FLAGS] = 8'hff;
  end

  // Lockout while supply is low, then a recovery wait
  always @(posedge powerFail) locked = 1'b1;
  always @(negedge powerFail)
  begin
    #(REC_NS);
    if (!powerFail)
      locked = 1'b0;
  end

  // Address latches, kept across cycles, either order
  always @(posedge lowAddrStrobeN) if (!locked) lowByte = busWire;
  always @(posedge highAddrStrobeN) if (!locked) highByte = busWire[4:0];
  assign addr = {highByte, lowByte};

  // Store at the end of the write pulse; flags ignore writes
  always @(posedge writeEnableN)
    if (!locked && !chipSelectN && addr != mbr_pkg::REG_STATUS_FLAGS)
      mem[addr] = busWire;

  always @*
  begin
    rdVal = mem[addr];
    if (addr == mbr_pkg::REG_STATUS_FLAGS)
      rdVal = mem[addr] & ~mbr_pkg::FLAGS_ZERO_MASK;
    drv = !locked && !readEnableN && !chipSelectN;
  end

  // Released bus shows the inverse of its last driven value
  assign busWire = (drv && !hostOeN) ? 8'hxx : drv ? rdVal : !hostOeN ? hostOut : ~lastVal;
  always @(busWire) if (drv || !hostOeN) lastVal = busWire;
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the multiplexed-bus host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int REC = 20;
  localparam logic [55:0] GOOD = 56'hd9592347311299;
  localparam logic [55:0] BAD = 56'h5a60240032139a;
  logic clk, rst, reqValid, reqWrite, powerFail, reqReady, rspValid, rspFault, linkReady;
  logic [12:0] reqAddr;
  logic [7:0] reqData, rspData, muxedBusOut, busWire, got;
  logic muxedBusOeN, lowAddrStrobeN, highAddrStrobeN, readEnableN, writeEnableN, chipSelectN;
  logic flt;
  int failures, n_compared, cycles, nLow, nHigh, lat, k;

  mbr_host #(.REC_CYCLES(REC)) u_mbr_host (.clk(clk), .rst(rst), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspFault(rspFault), .rspData(rspData), .linkReady(linkReady),
    .powerFail(powerFail), .muxedBusIn(busWire), .muxedBusOut(muxedBusOut),
    .muxedBusOeN(muxedBusOeN), .lowAddrStrobeN(lowAddrStrobeN),
    .highAddrStrobeN(highAddrStrobeN), .readEnableN(readEnableN),
    .writeEnableN(writeEnableN), .chipSelectN(chipSelectN));

  mbr_device_model u_mbr_device_model (.powerFail(powerFail), .lowAddrStrobeN(lowAddrStrobeN),
    .highAddrStrobeN(highAddrStrobeN), .readEnableN(readEnableN),
    .writeEnableN(writeEnableN), .chipSelectN(chipSelectN), .hostOut(muxedBusOut),
    .hostOeN(muxedBusOeN), .busWire(busWire));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Timeout and pin monitors
  always @(posedge clk)
  begin
    cycles++;
    if (!rst && (!readEnableN || !writeEnableN))
    begin
      check(16'(chipSelectN), 16'h0000);
      check(16'(readEnableN | writeEnableN), 16'h0001);
    end
    if (cycles == 6000)
    begin
      failures++;
      stop_test;
    end
  end
  always @(negedge lowAddrStrobeN) nLow++;
  always @(negedge highAddrStrobeN) nHigh++;
  always @(posedge highAddrStrobeN) if (!rst) check(16'(busWire[7:5]), 16'h0000);

  task automatic access(input logic wr, input logic [12:0] a, input logic [7:0] d, input int pfAt);
    @(posedge clk);
    #5;
    k = 0;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    while (!reqReady && k < 100)
    begin
      @(posedge clk);
      #5;
      k++;
    end
    @(posedge clk);
    #5;
    reqValid = 1'b0;
    lat = 1;
    while (!rspValid && lat < 40)
    begin
      if (lat == pfAt)
        powerFail = 1'b1;
      @(posedge clk);
      #5;
      lat++;
    end
    got = rspData;
    flt = rspFault;
    check(16'(rspValid), 16'h0001);
  endtask

  task automatic wait_link;
    k = 0;
    while (!linkReady && k < 100)
    begin
      @(posedge clk);
      #5;
      k++;
    end
    check(16'(linkReady), 16'h0001);
  endtask

  task automatic t_plain_rw;
    nLow = 0;
    nHigh = 0;
    access(1'b1, 13'h0a5c, 8'h3c, 99);
    check(16'(lat), 16'd9);
    check(16'(flt), 16'h0000);
    check(16'(u_mbr_device_model.mem[13'h0a5c]), 16'h003c);
    access(1'b0, 13'h0a5c, 8'h00, 99);
    check(16'(lat), 16'd3);
    check(16'(got), 16'h003c);
    check(16'(nLow + nHigh), 16'd2);
    access(1'b1, 13'h0b5c, 8'hc3, 99);
    check(16'(nHigh), 16'd2);
    check(16'(nLow), 16'd1);
    access(1'b0, 13'h0a5c, 8'h00, 99);
    check(16'(got), 16'h003c);
    check(16'(u_mbr_device_model.mem[13'h0b5c]), 16'h00c3);
  endtask

  task automatic t_registers;
    for (int i = 0; i < 8; i++)
    begin
      access(1'b1, mbr_pkg::REG_SPARE_BYTE + 13'(i), 8'ha5 ^ 8'(i * 17), 99);
      access(1'b0, mbr_pkg::REG_SPARE_BYTE + 13'(i), 8'h00, 99);
      check(16'(got), 16'(8'ha5 ^ 8'(i * 17)));
    end
    access(1'b1, mbr_pkg::REG_STATUS_FLAGS, 8'h00, 99);
    access(1'b0, mbr_pkg::REG_STATUS_FLAGS, 8'h00, 99);
    check(16'(got), 16'h00d0);
  endtask

  task automatic t_time_values;
    for (int i = 0; i < 7; i++)
    begin
      access(1'b1, mbr_pkg::REG_TIME_SECONDS + 13'(i), GOOD[55 - 8 * i -: 8], 99);
      check(16'(flt), 16'h0000);
      nLow = 0;
      access(1'b1, mbr_pkg::REG_TIME_SECONDS + 13'(i), BAD[55 - 8 * i -: 8], 99);
      check(16'({flt, 8'(lat)}), 16'h0101);
      check(16'(nLow), 16'h0000);
      access(1'b0, mbr_pkg::REG_TIME_SECONDS + 13'(i), 8'h00, 99);
      check(16'(got), 16'(GOOD[55 - 8 * i -: 8]));
    end
  endtask

  task automatic t_power_fail;
    access(1'b1, 13'h0123, 8'h77, 3);
    check(16'(flt), 16'h0001);
    check(16'(lat <= 5), 16'h0001);
    check(16'({lowAddrStrobeN, highAddrStrobeN, readEnableN, writeEnableN, chipSelectN,
      muxedBusOeN}), 16'h003f);
    check(16'({linkReady, reqReady}), 16'h0000);
    check(16'(u_mbr_device_model.mem[13'h0123]), 16'h0000);
    powerFail = 1'b0;
    wait_link();
    check(16'(k >= REC), 16'h0001);
    nLow = 0;
    nHigh = 0;
    access(1'b1, 13'h0123, 8'h77, 99);
    check(16'({8'(lat), 8'(nLow + nHigh)}), 16'h0902);
    check(16'(u_mbr_device_model.mem[13'h0123]), 16'h0077);
  endtask

  initial
  begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 13'h0000;
    reqData = 8'h00;
    powerFail = 1'b0;
    repeat (4) @(posedge clk);
    #5;
    check(16'({lowAddrStrobeN, highAddrStrobeN, readEnableN, writeEnableN, chipSelectN,
      muxedBusOeN, linkReady}), 16'h007e);
    rst = 1'b0;
    wait_link();
    check(16'(k), 16'(REC + 1));
    t_plain_rw();
    t_registers();
    t_time_values();
    t_power_fail();
    stop_test();
  end
endmodule
`default_nettype wire
